// File: keypad_scan_config_tb.sv
// Self-checking bench: scanner against a switch matrix model.
// Assumes the scanner's register port and key event contract.
`timescale 1ns/1ps
`default_nettype none
module keypad_scan_config_tb
  import ksc_pkg::*;
;
  typedef struct packed {logic [7:0] a, rst, d, exp;} ksc_row_t;
  ksc_row_t rows [6] = '{'{8'h60, 8'h00, 8'hA5, 8'hA5}, '{8'h61, 8'hC0, 8'hFF, 8'hE0},
    '{8'h62, 8'h00, 8'h3C, 8'h3C}, '{8'h63, 8'h00, 8'hF5, 8'hF5},
    '{8'h64, 8'h00, 8'hFE, 8'hFE}, '{8'h65, 8'h00, 8'hFF, 8'h00}};
  logic clk, rst_n, wr_en, rd_en, sleep, hib, key_valid, wake;
  logic [7:0] addr, wdata, rdata, col, col_pu, row, row_oe, row_pu, q;
  logic [63:0] keys;
  logic [3:0] dkeys, dk_down;
  ksc_key_event_t ev;
  int err_total, tests_run, n;
  ksc_scanner u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WR_EN_IN(wr_en),
    .REG_WDATA_IN(wdata), .REG_RD_EN_IN(rd_en), .REG_RDATA_OUT(rdata), .SLEEP_IN(sleep),
    .HIBERNATE_IN(hib), .WAKE_OUT(wake), .COL_IN(col), .COL_PULLUP_EN_OUT(col_pu),
    .ROW_OUT(row), .ROW_OE_OUT(row_oe), .ROW_PULLUP_EN_OUT(row_pu), .KEY_VALID_OUT(key_valid),
    .KEY_EVENT_OUT(ev), .DKEY_DOWN_OUT(dk_down));
  ksc_keypad_model u_keys (.clk_in(clk), .row_in(row), .row_oe_in(row_oe),
    .col_pullup_en_in(col_pu), .col_out(col), .key_down_in(keys), .dkey_down_in(dkeys));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask : rd
  // Bounded wait for one key event; cycles spent in cyc
  task automatic wait_ev(output int cyc);
    for (cyc = 0; cyc < 30000; cyc++) begin
      @(negedge clk);
      if (key_valid === 1'b1) break;
    end
    if (cyc == 30000) begin
      err_total++;
      print_verdict();
    end
  endtask : wait_ev
  task automatic key(input int k, input logic dn, input logic [7:0] exp);
    @(posedge clk);
    if (k < 64) keys[k] <= dn;
    else dkeys[k-64] <= dn;
    wait_ev(n);
    chk(ev, exp);
  endtask : key
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst_n, wr_en, rd_en, sleep, hib} = 5'h00;
    addr = 8'h00;
    wdata = 8'h00;
    keys = '0;
    dkeys = 4'h0;
    err_total = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(q, rows[i].rst);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(q, rows[i].exp);
    end
    wr(8'h63, 8'h00);
    wr(8'h60, 8'hDF);
    wr(8'h62, 8'h06);
    for (int pw = 0; pw < 4; pw++) begin
      wr(8'h64, 8'h00);
      wr(8'h61, {pw[1:0], 6'h00});
      wr(8'h64, 8'h01);
      if (pw == 0) begin
        // Disabled column and disabled row must stay silent
        keys[21] <= 1'b1;
        keys[3] <= 1'b1;
        n = 0;
        repeat (3000) begin
          @(negedge clk);
          if (key_valid !== 1'b0) n++;
        end
        chk(8'(n), 8'h00);
        keys <= '0;
        wr(8'h60, 8'hFF);
      end
      key(21, 1'b1, 8'h15);
      key(21, 1'b0, 8'h95);
    end
    wr(8'h64, 8'h05);
    key(21, 1'b1, 8'h15);
    chk(8'(n > 600), 8'h01);
    key(21, 1'b0, 8'h95);
    wr(8'h64, 8'h01);
    wr(8'h63, 8'hF0);
    key(21, 1'b1, 8'h15);
    chk(8'(n >= 3840), 8'h01);
    key(21, 1'b0, 8'h95);
    wr(8'h63, 8'h01);
    key(64, 1'b1, 8'h40);
    chk(8'(dk_down), 8'h01);
    key(64, 1'b0, 8'hC0);
    wr(8'h64, 8'h00);
    sleep <= 1'b1;
    wr(8'h64, 8'h01);
    key(21, 1'b1, 8'h15);
    key(21, 1'b0, 8'h95);
    wr(8'h64, 8'h00);
    @(negedge clk);
    chk(row_oe, 8'h00);
    chk(row, 8'h00);
    wr(8'h61, 8'hE0);
    hib <= 1'b1;
    dkeys[0] <= 1'b1;
    repeat (3) @(posedge clk);
    chk(8'(wake), 8'h01);
    wr(8'h61, 8'hC0);
    repeat (2) @(posedge clk);
    chk(8'(wake), 8'h00);
    print_verdict();
  end
endmodule : keypad_scan_config_tb
`default_nettype wire

// File: ksc_debounce.sv
// Debounce of the full key state vector, matrix plus dedicated keys.
// Assumes samples arrive once per scan cycle and tick_in at 32 kHz.
`timescale 1ns/1ps
`default_nettype none
module ksc_debounce
  import ksc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Samples
  input wire logic sample_stb_in,
  input wire logic [KEY_BITS-1:0] sample_in,
  input wire logic tick_in,
  input wire logic [6:0] limit_in,
  // Result
  output logic [KEY_BITS-1:0] confirmed_out,
  output logic busy_out
);

  typedef struct packed {
    logic [KEY_BITS-1:0] candidate;
    logic [KEY_BITS-1:0] confirmed;
    logic [6:0] count;
  } ksc_db_state_t;

  ksc_db_state_t state_r;
  ksc_db_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (sample_stb_in && (sample_in != state_r.candidate)) begin
      state_nxt.candidate = sample_in;
      state_nxt.count = '0;
    end else if (tick_in && (state_r.count < limit_in)) begin
      state_nxt.count = state_r.count + 7'h01;
    end
    // Confirm only once the change held for the whole setting
    if (state_r.count >= limit_in) begin
      state_nxt.confirmed = state_r.candidate;
    end
  end

  assign confirmed_out = state_r.confirmed;
  assign busy_out = (state_r.candidate != state_r.confirmed);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule : ksc_debounce
`default_nettype wire

// File: ksc_keypad_model.sv
// Switch matrix model on the scanner's row and column pins.
// Assumes a row pulls low only while enabled and driven with 0.
`timescale 1ns/1ps
`default_nettype none
module ksc_keypad_model
  import ksc_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Pins
  input wire logic [NUM_ROWS-1:0] row_in,
  input wire logic [NUM_ROWS-1:0] row_oe_in,
  input wire logic [NUM_COLS-1:0] col_pullup_en_in,
  output logic [NUM_COLS-1:0] col_out,
  // Switch states
  input wire logic [MAT_BITS-1:0] key_down_in,
  input wire logic [NUM_DKEYS-1:0] dkey_down_in
);
  logic float_r = 1'b0;
  logic [NUM_COLS-1:0] low;
  // Unpulled column wanders every cycle
  always_ff @(posedge clk_in) float_r <= ~float_r;
  always_comb begin
    for (int c = 0; c < NUM_COLS; c++) begin
      low[c] = (c < NUM_DKEYS) && dkey_down_in[c % NUM_DKEYS];
      for (int r = 0; r < NUM_ROWS; r++)
        low[c] |= key_down_in[r*NUM_COLS+c] && row_oe_in[r] && !row_in[r];
      col_out[c] = low[c] ? 1'b0 : (col_pullup_en_in[c] ? 1'b1 : float_r);
    end
  end
endmodule : ksc_keypad_model
`default_nettype wire

// File: ksc_pkg.sv
// Keypad scan configuration: shared constants, register map and carrier types.
// Assumes a single 20 MHz clock; the 32 kHz sleep rate is derived by division.
package ksc_pkg;

  // Clocking
  localparam int CLK_HZ = 20_000_000;
  localparam int SLOW_CLK_HZ = 32_768;
  localparam int SLOW_DIV_W = 10;
  localparam logic [SLOW_DIV_W-1:0] SLOW_DIV_LAST = SLOW_DIV_W'((CLK_HZ / SLOW_CLK_HZ) - 1);

  // Matrix geometry
  localparam int NUM_ROWS = 8;
  localparam int NUM_COLS = 8;
  localparam int NUM_DKEYS = 4;
  localparam int MAT_BITS = NUM_ROWS * NUM_COLS;
  localparam int KEY_BITS = MAT_BITS + NUM_DKEYS;
  localparam int KEY_IDX_W = 7;

  // Register offsets
  localparam logic [7:0] ADDR_COL_EN = 8'h60;
  localparam logic [7:0] ADDR_PULSE_WAKE = 8'h61;
  localparam logic [7:0] ADDR_ROW_EN = 8'h62;
  localparam logic [7:0] ADDR_SCNT_DKEY = 8'h63;
  localparam logic [7:0] ADDR_DB_RUN = 8'h64;

  // Reset values
  localparam logic [7:0] RST_COL_EN = 8'h00;
  localparam logic [7:0] RST_PULSE_WAKE = 8'hC0;
  localparam logic [7:0] RST_ROW_EN = 8'h00;
  localparam logic [7:0] RST_SCNT_DKEY = 8'h00;
  localparam logic [7:0] RST_DB_RUN = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Field positions
  localparam int PW_HI = 7;
  localparam int PW_LO = 6;
  localparam int WAKE_BIT = 5;
  localparam int SCNT_HI = 7;
  localparam int SCNT_LO = 4;
  localparam int DKEY_HI = 3;
  localparam int DB_HI = 7;
  localparam int DB_LO = 1;
  localparam int RUN_BIT = 0;

  // Row pulse widths in internal clock periods
  localparam logic [1:0] PW_CODE_1X = 2'h0;
  localparam logic [1:0] PW_CODE_16X = 2'h1;
  localparam logic [1:0] PW_CODE_64X = 2'h2;
  localparam logic [7:0] PW_CYC_1X = 8'h01;
  localparam logic [7:0] PW_CYC_16X = 8'h10;
  localparam logic [7:0] PW_CYC_64X = 8'h40;
  localparam logic [7:0] PW_CYC_128X = 8'h80;

  typedef struct packed {
    logic [7:0] col_scan_enable;
    logic [1:0] row_pulse_width;
    logic hibernate_wake_enable;
    logic [7:0] row_scan_enable;
    logic [3:0] scan_count;
    logic [3:0] direct_key;
    logic [6:0] debounce_setting;
    logic run;
  } ksc_regs_t;

  typedef struct packed {
    logic up;
    logic dedicated;
    logic [2:0] row;
    logic [2:0] col;
  } ksc_key_event_t;

  typedef enum logic {ST_IDLE, ST_SCAN} ksc_state_t;

endpackage : ksc_pkg

// File: ksc_row_timer.sv
// Row pulse timer and 32 kHz tick divider for the keypad scanner.
// Assumes restart_in is asserted in the cycle a new row is selected.
`timescale 1ns/1ps
`default_nettype none
module ksc_row_timer
  import ksc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic restart_in,
  input wire logic sleep_in,
  input wire logic [1:0] pw_code_in,
  // Status
  output logic slow_tick_out,
  output logic done_out
);

  typedef struct packed {
    logic [SLOW_DIV_W-1:0] div;
    logic [7:0] cnt;
  } ksc_tmr_state_t;

  ksc_tmr_state_t state_r;
  ksc_tmr_state_t state_nxt;
  logic [7:0] limit;

  always_comb begin
    case (pw_code_in)
      PW_CODE_1X: limit = PW_CYC_1X;
      PW_CODE_16X: limit = PW_CYC_16X;
      PW_CODE_64X: limit = PW_CYC_64X;
      default: limit = PW_CYC_128X;
    endcase
  end

  assign slow_tick_out = (state_r.div == SLOW_DIV_LAST);
  // Sleep: one full slow period, tick to tick
  assign done_out = sleep_in ? slow_tick_out : (state_r.cnt == limit - 8'h01);

  always_comb begin
    state_nxt = state_r;
    state_nxt.div = slow_tick_out ? '0 : state_r.div + SLOW_DIV_W'(1);
    if (restart_in) begin
      state_nxt.cnt = '0;
    end else if (state_r.cnt != 8'hFF) begin
      state_nxt.cnt = state_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule : ksc_row_timer
`default_nettype wire

// File: ksc_scanner.sv
// Keypad matrix scanner with its configuration registers.
// Assumes register strobes and key pins are synchronous to CLK_IN.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Column enable bits include or exclude each column; all off after reset.
// - Pulse width code gives 1, 16, 64 or 128 clocks; default 128.
// - In sleep each row pulse lasts exactly one 32 kHz period.
// - Wake bit lets key activity wake from hibernation; clear blocks it.
// - Row enable bits include or exclude each row output in scanning.
// - Scan count field sets cycles waited before confirmed key data queued.
// - Low four control bits turn columns 3 to 0 into dedicated keys.
// - Run bit starts scanning when one, stops when zero; stopped after reset.
// - Seven-bit debounce setting is readable, writable, reset to zero.
// - Every key change is debounced for the set time before confirmation.
// - Enabled rows driven low one at a time while scanning, all together while waiting; others released with pull-ups.
// - Enabled columns rest high on internal pull-ups.
module ksc_scanner
  import ksc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // Register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_EN_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_RD_EN_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Power state
  input wire logic SLEEP_IN,
  input wire logic HIBERNATE_IN,
  output logic WAKE_OUT,
  // Matrix pins
  input wire logic [NUM_COLS-1:0] COL_IN,
  output logic [NUM_COLS-1:0] COL_PULLUP_EN_OUT,
  output logic [NUM_ROWS-1:0] ROW_OUT,
  output logic [NUM_ROWS-1:0] ROW_OE_OUT,
  output logic [NUM_ROWS-1:0] ROW_PULLUP_EN_OUT,
  // Key events
  output logic KEY_VALID_OUT,
  output ksc_key_event_t KEY_EVENT_OUT,
  output logic [NUM_DKEYS-1:0] DKEY_DOWN_OUT
);

  typedef struct packed {
    ksc_regs_t regs;
    ksc_state_t state;
    logic [2:0] row_idx;
    logic [MAT_BITS-1:0] matrix;
    logic [KEY_BITS-1:0] reported;
    logic [3:0] wait_cnt;
    logic emit;
    logic [7:0] rd_data;
    logic key_valid;
    ksc_key_event_t key_event;
    logic [NUM_ROWS-1:0] row_oe;
    logic wake;
  } ksc_top_state_t;

  ksc_top_state_t state_r;
  ksc_top_state_t state_nxt;

  logic restart;
  logic smp_stb;
  logic tmr_done;
  logic slow_tick;
  logic db_busy;
  logic [KEY_BITS-1:0] confirmed;
  logic [KEY_BITS-1:0] sample_vec;
  logic [NUM_COLS-1:0] mat_cols;
  logic [NUM_COLS-1:0] col_low;
  logic [NUM_DKEYS-1:0] dkey_raw;
  logic [3:0] nr;
  logic [7:0] fd;

  // Lowest enabled row at or above a start index
  function automatic logic [3:0] next_row(input logic [7:0] en, input logic [3:0] from);
    logic [3:0] res;
    res = '0;
    for (int i = NUM_ROWS - 1; i >= 0; i--) begin
      if (en[i] && (4'(i) >= from)) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction : next_row

  // Lowest bit where two key vectors differ
  function automatic logic [7:0] first_diff(input logic [KEY_BITS-1:0] a,
                                            input logic [KEY_BITS-1:0] b);
    logic [7:0] res;
    res = '0;
    for (int i = KEY_BITS - 1; i >= 0; i--) begin
      if (a[i] != b[i]) begin
        res = {1'b1, 7'(i)};
      end
    end
    return res;
  endfunction : first_diff

  ksc_row_timer u_timer (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .restart_in(restart),
    .sleep_in(SLEEP_IN),
    .pw_code_in(state_r.regs.row_pulse_width),
    .slow_tick_out(slow_tick),
    .done_out(tmr_done)
  );

  ksc_debounce u_debounce (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .sample_stb_in(smp_stb),
    .sample_in(sample_vec),
    .tick_in(slow_tick),
    .limit_in(state_r.regs.debounce_setting),
    .confirmed_out(confirmed),
    .busy_out(db_busy)
  );

  // Column roles
  assign mat_cols = state_r.regs.col_scan_enable
                    & ~{{(NUM_COLS-NUM_DKEYS){1'b0}}, state_r.regs.direct_key};
  assign col_low = ~COL_IN;
  assign dkey_raw = state_r.regs.direct_key & col_low[NUM_DKEYS-1:0];

  always_comb begin
    state_nxt = state_r;
    state_nxt.key_valid = 1'b0;
    restart = 1'b0;
    smp_stb = 1'b0;
    nr = '0;
    fd = '0;

    // Register writes
    if (REG_WR_EN_IN) begin
      case (REG_ADDR_IN)
        ADDR_COL_EN: state_nxt.regs.col_scan_enable = REG_WDATA_IN;
        ADDR_PULSE_WAKE: begin
          state_nxt.regs.row_pulse_width = REG_WDATA_IN[PW_HI:PW_LO];
          state_nxt.regs.hibernate_wake_enable = REG_WDATA_IN[WAKE_BIT];
        end
        ADDR_ROW_EN: state_nxt.regs.row_scan_enable = REG_WDATA_IN;
        ADDR_SCNT_DKEY: begin
          state_nxt.regs.scan_count = REG_WDATA_IN[SCNT_HI:SCNT_LO];
          state_nxt.regs.direct_key = REG_WDATA_IN[DKEY_HI:0];
        end
        ADDR_DB_RUN: begin
          state_nxt.regs.debounce_setting = REG_WDATA_IN[DB_HI:DB_LO];
          state_nxt.regs.run = REG_WDATA_IN[RUN_BIT];
        end
        default: ;
      endcase
    end

    // Register reads
    if (REG_RD_EN_IN) begin
      case (REG_ADDR_IN)
        ADDR_COL_EN: state_nxt.rd_data = state_r.regs.col_scan_enable;
        ADDR_PULSE_WAKE: state_nxt.rd_data = {state_r.regs.row_pulse_width,
                                              state_r.regs.hibernate_wake_enable,
                                              5'h00};
        ADDR_ROW_EN: state_nxt.rd_data = state_r.regs.row_scan_enable;
        ADDR_SCNT_DKEY: state_nxt.rd_data = {state_r.regs.scan_count, state_r.regs.direct_key};
        ADDR_DB_RUN: state_nxt.rd_data = {state_r.regs.debounce_setting, state_r.regs.run};
        default: state_nxt.rd_data = READ_NONE;
      endcase
    end

    // Scan sequencer
    case (state_r.state)
      ST_IDLE: begin
        if (state_r.regs.run
            // A held matrix key keeps the scan going so that its release is seen
            && ((|(col_low & mat_cols)) || (dkey_raw != confirmed[KEY_BITS-1:MAT_BITS])
                || db_busy || (confirmed != state_r.reported)
                || (|confirmed[MAT_BITS-1:0]))
            && (tmr_done || !SLEEP_IN)) begin
          nr = next_row(state_r.regs.row_scan_enable, 4'h0);
          state_nxt.matrix = '0;
          if (nr[3]) begin
            state_nxt.state = ST_SCAN;
            state_nxt.row_idx = nr[2:0];
            restart = 1'b1;
          end else begin
            smp_stb = 1'b1;
          end
        end
      end
      ST_SCAN: begin
        if (!state_r.regs.run) begin
          state_nxt.state = ST_IDLE;
        end else if (tmr_done) begin
          for (int c = 0; c < NUM_COLS; c++) begin
            state_nxt.matrix[{state_r.row_idx, 3'(c)}] = mat_cols[c] & col_low[c];
          end
          nr = next_row(state_r.regs.row_scan_enable, {1'b0, state_r.row_idx} + 4'h1);
          if (nr[3]) begin
            state_nxt.row_idx = nr[2:0];
            restart = 1'b1;
          end else begin
            state_nxt.state = ST_IDLE;
            smp_stb = 1'b1;
          end
        end
      end
      default: state_nxt.state = ST_IDLE;
    endcase

    // Hold-off and event output
    if (state_r.emit) begin
      fd = first_diff(confirmed, state_r.reported);
      if (fd[7]) begin
        state_nxt.key_valid = 1'b1;
        state_nxt.key_event.up = ~confirmed[fd[6:0]];
        state_nxt.key_event.dedicated = (fd[6:0] >= KEY_IDX_W'(MAT_BITS));
        state_nxt.key_event.row = fd[5:3];
        state_nxt.key_event.col = fd[2:0];
        state_nxt.reported[fd[6:0]] = confirmed[fd[6:0]];
      end else begin
        state_nxt.emit = 1'b0;
        state_nxt.wait_cnt = '0;
      end
    end else if (confirmed != state_r.reported) begin
      if (state_r.wait_cnt >= state_r.regs.scan_count) begin
        state_nxt.emit = 1'b1;
      end else if (smp_stb) begin
        state_nxt.wait_cnt = state_r.wait_cnt + 4'h1;
      end
    end

    // Row drive: all enabled rows while waiting, one while scanning
    state_nxt.row_oe = '0;
    if (state_nxt.regs.run) begin
      if (state_nxt.state == ST_SCAN) begin
        state_nxt.row_oe[state_nxt.row_idx] = 1'b1;
      end else begin
        state_nxt.row_oe = state_nxt.regs.row_scan_enable;
      end
    end

    state_nxt.wake = HIBERNATE_IN && state_r.regs.hibernate_wake_enable
                     && (|(col_low & (mat_cols | {4'h0, state_r.regs.direct_key})));
  end

  assign sample_vec = {dkey_raw, state_nxt.matrix};

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= '0;
      state_r.regs.col_scan_enable <= RST_COL_EN;
      state_r.regs.row_pulse_width <= RST_PULSE_WAKE[PW_HI:PW_LO];
      state_r.regs.hibernate_wake_enable <= RST_PULSE_WAKE[WAKE_BIT];
      state_r.regs.row_scan_enable <= RST_ROW_EN;
      state_r.regs.scan_count <= RST_SCNT_DKEY[SCNT_HI:SCNT_LO];
      state_r.regs.direct_key <= RST_SCNT_DKEY[DKEY_HI:0];
      state_r.regs.debounce_setting <= RST_DB_RUN[DB_HI:DB_LO];
      state_r.regs.run <= RST_DB_RUN[RUN_BIT];
      state_r.state <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign REG_RDATA_OUT = state_r.rd_data;
  assign WAKE_OUT = state_r.wake;
  assign ROW_OUT = '0;
  assign ROW_OE_OUT = state_r.row_oe;
  assign ROW_PULLUP_EN_OUT = ~state_r.row_oe;
  assign COL_PULLUP_EN_OUT = state_r.regs.col_scan_enable
                             | {4'h0, state_r.regs.direct_key};
  assign KEY_VALID_OUT = state_r.key_valid;
  assign KEY_EVENT_OUT = state_r.key_event;
  assign DKEY_DOWN_OUT = state_r.reported[KEY_BITS-1:MAT_BITS];

endmodule : ksc_scanner
`default_nettype wire

// File: ksc_scanner_monitor.sv
// Port checker for the keypad scanner, bound below.
// Assumes the register port contract of the scanner.
`timescale 1ns/1ps
`default_nettype none
module ksc_scanner_monitor
  import ksc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // Register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_EN_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_RD_EN_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  // Power and pins
  input wire logic SLEEP_IN,
  input wire logic HIBERNATE_IN,
  input wire logic WAKE_OUT,
  input wire logic [NUM_COLS-1:0] COL_IN,
  input wire logic [NUM_COLS-1:0] COL_PULLUP_EN_OUT,
  input wire logic [NUM_ROWS-1:0] ROW_OE_OUT,
  input wire logic [NUM_ROWS-1:0] ROW_PULLUP_EN_OUT
);
  logic [7:0] shd_r [5];
  logic [7:0] prev_oe_r;
  logic [9:0] cnt_r;
  logic [7:0] off_w, rd_exp, pu_exp, pw_cyc;
  logic wake_cond;
  always_comb begin
    off_w = REG_ADDR_IN - ADDR_COL_EN;
    rd_exp = (off_w < 8'h05) ? shd_r[off_w[2:0]] : READ_NONE;
    pu_exp = shd_r[0] | {4'h0, shd_r[3][3:0]};
    wake_cond = HIBERNATE_IN && shd_r[1][WAKE_BIT] && |(~COL_IN & pu_exp);
    case (shd_r[1][PW_HI:PW_LO])
      PW_CODE_1X: pw_cyc = PW_CYC_1X;
      PW_CODE_16X: pw_cyc = PW_CYC_16X;
      PW_CODE_64X: pw_cyc = PW_CYC_64X;
      default: pw_cyc = PW_CYC_128X;
    endcase
  end
  // Register shadow and row pulse length counter
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      shd_r <= '{RST_COL_EN, RST_PULSE_WAKE, RST_ROW_EN, RST_SCNT_DKEY, RST_DB_RUN};
      prev_oe_r <= 8'h00;
      cnt_r <= 10'h000;
    end else begin
      if (REG_WR_EN_IN && off_w < 8'h05)
        shd_r[off_w[2:0]] <= (off_w == 8'h01) ? (REG_WDATA_IN & 8'hE0) : REG_WDATA_IN;
      prev_oe_r <= ROW_OE_OUT;
      cnt_r <= (ROW_OE_OUT != prev_oe_r) ? 10'h001 : cnt_r + 10'h001;
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence row_step;
    ROW_OE_OUT != prev_oe_r && $onehot(prev_oe_r) && $onehot(ROW_OE_OUT);
  endsequence
  rdata_a: assert property (REG_RD_EN_IN |=> REG_RDATA_OUT == $past(rd_exp))
    else $error("read data differs");
  rdata_hold_a: assert property (!REG_RD_EN_IN |=> $stable(REG_RDATA_OUT))
    else $error("read data moved");
  row_pullup_a: assert property (ROW_PULLUP_EN_OUT == ~ROW_OE_OUT)
    else $error("row pull-up wrong");
  row_drive_a: assert property ($onehot0(ROW_OE_OUT) || ROW_OE_OUT == shd_r[2])
    else $error("rows not driven one at a time");
  row_enable_a: assert property ((ROW_OE_OUT & ~shd_r[2]) == 8'h00)
    else $error("disabled row driven");
  scan_stop_a: assert property (!shd_r[4][RUN_BIT] |-> ROW_OE_OUT == 8'h00)
    else $error("rows driven while stopped");
  col_pullup_a: assert property (COL_PULLUP_EN_OUT == pu_exp)
    else $error("column pull-up wrong");
  wake_a: assert property (1'b1 |=> WAKE_OUT == $past(wake_cond))
    else $error("wake output wrong");
  pulse_width_a: assert property (!SLEEP_IN ##0 row_step |-> cnt_r == {2'b00, pw_cyc})
    else $error("row pulse width wrong");
  pulse_sleep_a: assert property (SLEEP_IN ##0 row_step |-> cnt_r == 10'h262)
    else $error("sleep row pulse wrong");
endmodule : ksc_scanner_monitor
bind ksc_scanner ksc_scanner_monitor u_mon (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_EN_IN(REG_WR_EN_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_RD_EN_IN(REG_RD_EN_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .SLEEP_IN(SLEEP_IN),
  .HIBERNATE_IN(HIBERNATE_IN), .WAKE_OUT(WAKE_OUT), .COL_IN(COL_IN),
  .COL_PULLUP_EN_OUT(COL_PULLUP_EN_OUT), .ROW_OE_OUT(ROW_OE_OUT),
  .ROW_PULLUP_EN_OUT(ROW_PULLUP_EN_OUT));
`default_nettype wire
